// ### mar_map.vh
// opcode encodings and field positions for the move and return decoder
// Notes on behaviour
// - file-to-acc move loads W, updates zero flag
// - literal load sets W, flags untouched
// - acc-to-file store writes W to file
// - subroutine return pops stack into PC, two cycles
// - interrupt return pops stack, two cycles, no flags
// - interrupt return sets global interrupt enable
// - return with literal loads W and PC
`ifndef MAR_MAP_VH
`define MAR_MAP_VH
`define MAR_OP_NOP 16'h0000
`define MAR_OP_RET 16'h0040
`define MAR_OP_INTERRUPT_RETURN 16'h0060
`define MAR_OP_RETURN_WITH_LITERAL_HI 8'h18
`define MAR_OP_LDLIT_HI 8'h19
`define MAR_OP_MOVE_MASK 16'h3F80
`define MAR_OP_MOVE_VAL 16'h0800
`define MAR_OP_STORE_VAL 16'h0080
`define MAR_ADDR_LO_MSB 6
`define MAR_ADDR_HI_MSB 15
`define MAR_ADDR_HI_LSB 14
`define MAR_RST_PC 13'h0000
`define MAR_RST_ACC 8'h00
`endif

// ### mar_stack.v
// hardware return stack, flip-flop storage addressed by a pointer
`timescale 1ns/1ps
module mar_stack #(
  parameter DEPTH = 8,
  parameter PW = 3,
  parameter AW = 13
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // push and pop
  input wire push,
  input wire [AW-1:0] push_data,
  input wire pop,
  output wire [AW-1:0] top
);
  reg [AW-1:0] mem_q [0:DEPTH-1];
  reg [PW-1:0] ptr_q;
  wire [PW-1:0] ptr_dn;
  integer i;
  assign ptr_dn = ptr_q - {{(PW-1){1'b0}}, 1'b1};
  // circular on overflow, like the small stacks such cores carry
  assign top = mem_q[ptr_dn];
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ptr_q <= {PW{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {AW{1'b0}};
      end
    end else if (push) begin
      mem_q[ptr_q] <= push_data;
      ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
    end else if (pop) begin
      ptr_q <= ptr_dn;
    end
  end
endmodule

// ### mar_decode.v
// decoder and executor for move, literal load, no-op and return opcodes
`timescale 1ns/1ps
`include "mar_map.vh"
module mar_decode #(
  parameter AW = 13,
  parameter DEPTH = 8,
  parameter PW = 3
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // instruction fetch
  input wire [15:0] instr,
  output reg [AW-1:0] pc_q,
  // file register port
  output reg [8:0] file_addr_q,
  input wire [7:0] file_rdata,
  output reg [7:0] file_wdata_q,
  output reg file_we_q,
  // core state
  output reg [7:0] acc_q,
  output reg zero_q,
  output reg global_irq_enable_q,
  output reg busy_q,
  // stack push from the call logic elsewhere, and interrupt disable
  input wire call_push,
  input wire [AW-1:0] call_addr,
  input wire irq_disable
);
  localparam S_RUN = 2'b01;
  localparam S_RET = 2'b10;
  reg [1:0] state_q;
  wire [AW-1:0] stack_top;
  wire [8:0] faddr;
  wire [7:0] lit;
  wire is_nop, is_ret, is_interrupt_return, is_return_with_literal, is_ldlit, is_move, is_store, is_pop;
  reg pop_d;

  assign faddr = {instr[`MAR_ADDR_HI_MSB:`MAR_ADDR_HI_LSB], instr[`MAR_ADDR_LO_MSB:0]};
  assign lit = instr[7:0];
  assign is_nop = (instr == `MAR_OP_NOP);
  assign is_ret = (instr == `MAR_OP_RET);
  assign is_interrupt_return = (instr == `MAR_OP_INTERRUPT_RETURN);
  assign is_return_with_literal = (instr[15:8] == `MAR_OP_RETURN_WITH_LITERAL_HI);
  assign is_ldlit = (instr[15:8] == `MAR_OP_LDLIT_HI);
  assign is_move = ((instr & `MAR_OP_MOVE_MASK) == `MAR_OP_MOVE_VAL);
  assign is_store = ((instr & `MAR_OP_MOVE_MASK) == `MAR_OP_STORE_VAL);
  assign is_pop = is_ret | is_interrupt_return | is_return_with_literal;

  mar_stack #(.DEPTH(DEPTH), .PW(PW), .AW(AW)) u_stack (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .push(call_push),
    .push_data(call_addr),
    .pop(pop_d),
    .top(stack_top)
  );

  always @* begin
    pop_d = (state_q == S_RET);
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= S_RUN;
      pc_q <= `MAR_RST_PC;
      acc_q <= `MAR_RST_ACC;
      zero_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
      busy_q <= 1'b0;
      file_addr_q <= 9'h000;
      file_wdata_q <= 8'h00;
      file_we_q <= 1'b0;
    end else begin
      file_we_q <= 1'b0;
      if (irq_disable) begin
        global_irq_enable_q <= 1'b0;
      end
      case (state_q)
        S_RUN: begin
          if (is_pop) begin
            // second cycle does the pop; pc holds meanwhile
            state_q <= S_RET;
            busy_q <= 1'b1;
            if (is_return_with_literal) begin
              acc_q <= lit;
            end
          end else begin
            pc_q <= pc_q + {{(AW-1){1'b0}}, 1'b1};
            if (is_move) begin
              acc_q <= file_rdata;
              zero_q <= (file_rdata == 8'h00);
            end
            if (is_ldlit) begin
              acc_q <= lit;
            end
            if (is_store) begin
              file_addr_q <= faddr;
              file_wdata_q <= acc_q;
              file_we_q <= 1'b1;
            end
            if (is_nop) begin
              state_q <= S_RUN;
            end
          end
        end
        S_RET: begin
          pc_q <= stack_top;
          state_q <= S_RUN;
          busy_q <= 1'b0;
          if (is_interrupt_return) begin
            global_irq_enable_q <= 1'b1;
          end
        end
        default: begin
          state_q <= S_RUN;
          busy_q <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### mar_checker_assertions.sv
// port checks for the move and return decoder
`timescale 1ns/1ps
module mar_checker #(parameter AW = 13) (
  // clock, reset and control
  input wire clk_sys, rst_b, file_we_q, zero_q, global_irq_enable_q, busy_q,
  // buses
  input wire [15:0] instr,
  input wire [AW-1:0] pc_q,
  input wire [8:0] file_addr_q,
  input wire [7:0] file_rdata, file_wdata_q, acc_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire mv = !busy_q && (instr & 16'h3f80) == 16'h0800;
  wire st = !busy_q && (instr & 16'h3f80) == 16'h0080;
  wire rt = !busy_q && (instr == 16'h0040 || instr == 16'h0060 || instr[15:8] == 8'h18);
  a_move_acc: assert property (
    mv |=> acc_q == $past(file_rdata)) else $error("move value");
  a_move_zero: assert property (
    mv |=> zero_q == (acc_q == 8'h00)) else $error("zero flag");
  a_lit_load: assert property (
    !busy_q && instr[15:8] == 8'h19 |=> acc_q == $past(instr[7:0]) && $stable(zero_q))
    else $error("literal load");
  a_store_write: assert property (
    st |=> file_we_q && file_wdata_q == $past(acc_q)
    && file_addr_q == {$past(instr[15:14]), $past(instr[6:0])}) else $error("store");
  a_ret_two: assert property (
    rt |=> busy_q ##1 !busy_q && $stable(zero_q)) else $error("return length");
  a_interrupt_return_gie: assert property (
    !busy_q && instr == 16'h0060 |-> ##2 global_irq_enable_q) else $error("enable");
  a_return_with_literal_acc: assert property (
    !busy_q && instr[15:8] == 8'h18 |=> acc_q == $past(instr[7:0])) else $error("return_with_literal");
  a_nop_pc: assert property (
    !busy_q && instr == 16'h0000 |=> pc_q == AW'($past(pc_q) + 1) && $stable(acc_q))
    else $error("no-op");
endmodule
bind mar_decode mar_checker #(.AW(AW)) i_mar_checker (.*);

// ### mar_decode_tb.sv
// random instruction stream against a behavioural core model
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module mar_decode_tb;
  logic clk_sys = 0, rst_b = 0, call_push = 0, irq_disable = 0, z = 0, global_irq_enable = 0;
  logic [15:0] instr = 0;
  logic [12:0] call_addr = 0, pc = 0, stk[$];
  logic [7:0] fm[512], mm[512], acc = 0;
  logic [31:0] seed = 32'h927a, r;
  int num_errors = 0, comparisons = 0, cyc = 0;
  wire [12:0] pc_q;
  wire [8:0] file_addr_q, fa = {instr[15:14], instr[6:0]};
  wire [7:0] file_wdata_q, acc_q;
  wire file_we_q, zero_q, global_irq_enable_q, busy_q;
  mar_decode i_mar_decode (.*, .file_rdata(fm[fa]));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task step(input [15:0] w, input bit p, d);
    instr = w;
    call_push = p;
    irq_disable = d;
    call_addr = 13'(rnd());
    @(posedge clk_sys);
    #1;
    call_push = 0;
    irq_disable = 0;
    if (p) stk.push_back(call_addr);
    if (d) global_irq_enable = 0;
    pc = pc + 1;
    casez (w)
      16'h0040, 16'h0060, 16'h18??: begin
        if (w[12]) acc = w[7:0];
        `CHK("busy", 1'b1, busy_q)
        @(posedge clk_sys);
        #1;
        pc = stk.pop_back();
        if (w == 16'h0060) global_irq_enable = 1;
      end
      16'h19??: acc = w[7:0];
      16'b??00_1000_0???_????: begin
        acc = mm[fa];
        z = acc == 0;
      end
      16'b??00_0000_1???_????: begin
        `CHK("we", 1'b1, file_we_q)
        `CHK("addr", fa, file_addr_q)
        `CHK("wdata", acc, file_wdata_q)
        mm[fa] = acc;
        // land the write now so a move on the very next edge reads it
        if (file_we_q === 1'b1) fm[file_addr_q] = file_wdata_q;
      end
      default: ;
    endcase
    `CHK("pc", pc, pc_q)
    `CHK("acc", acc, acc_q)
    `CHK("zero", z, zero_q)
    `CHK("gie", global_irq_enable, global_irq_enable_q)
  endtask
  always @(posedge clk_sys) begin
    if (++cyc > 4000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial forever #20 clk_sys = ~clk_sys;
  initial begin
    foreach (fm[i]) begin
      fm[i] = i[1] ? 8'(rnd()) : 8'h00;
      mm[i] = fm[i];
    end
    repeat (16) @(posedge clk_sys);
    #1 rst_b = 1;
    repeat (400) begin
      r = rnd();
      case (r[2:0])
        0: step(16'h0000, stk.size() < 8, 0);
        1: step({8'h19, r[15:8]}, 0, 0);
        2: step({r[15:14], 7'h10, r[22:16]}, 0, 0);
        3: step({r[15:14], 7'h01, r[22:16]}, 0, r[5]);
        default: if (stk.size() > 0)
          step(r[4] ? {8'h18, r[15:8]} : (r[3] ? 16'h0060 : 16'h0040), 0, r[6]);
          else step(16'h0000, 1, 1);
      endcase
    end
    end_of_test();
  end
endmodule
